// *** hw/dao_audio_out.sv ***
/*
  Audio output section of a serial-link video deserializer: takes encrypted
  audio packets from blanking periods, regenerates the bit clock and drives
  the serial audio pins, master clock and the reusable low colour pins.
  Assumes a classic Wishbone master on core_clk and a recovered pixel clock
  on link_clk; the cipher engine supplies a keystream word per packet.
  // What this block does
  // - 24-bit mode drives bit, word clocks, data, master clock
  // - Take audio and clock packets only in blanking
  // - Decrypt audio with the video keystream first
  // - 18-bit mode adds secondary data on the bit clock
  // - Strap or register bit selects secondary mode
  // - Master clock x1, x2, x4; off without PLL
  // - Master clock defaults to twice bit clock
  // - Code steps by one per frequency doubling
  // - Low red and green pins become general pins
  // - Pixel range 15-85 MHz, or 5-15 in low mode
*/
`timescale 1ns/10ps
`default_nettype none
module dao_audio_out
  import dao_pkg::*;
#(
  parameter int PKT_W = 24
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mode strap pin
  input wire logic strap_secondary,
  // Link side: recovered pixel clock, packets, cipher keystream
  input wire logic link_clk,
  input wire logic video_blank,
  input wire logic pkt_valid,
  input wire logic pkt_kind,
  input wire logic [PKT_W-1:0] pkt_word,
  input wire logic [PKT_W-1:0] keystream,
  // Serial audio outputs
  output logic audio_bit_clock,
  output logic audio_word_clock,
  output logic audio_primary_data,
  output logic audio_secondary_data,
  output logic audio_master_clock,
  // Low red and green pins reused as general pins
  input wire logic [3:0] gpio_i,
  output logic [3:0] gpio_o,
  output logic [3:0] gpio_oe,
  // Mode outputs to the rest of the deserializer
  output logic low_frequency_mode,
  output logic secondary_mode
);
  initial begin
    if (PKT_W != 3 * SLOTS) $error("dao_audio_out: packet must hold three slot bytes");
  end

  // Core domain registers
  logic [7:0] ctl_ff, nxt_ctl; // Audio control
  logic [7:0] mcs_ff, nxt_mcs; // Master clock select
  logic [7:0] gpc_ff, nxt_gpc; // General pins: [3:0] level, [7:4] drive
  logic ack_ff, nxt_ack; // Bus answer
  logic [31:0] rdat_ff, nxt_rdat; // Read data
  logic strap_s1_ff, strap_s2_ff; // Strap synchroniser
  logic strap_ff, nxt_strap; // Strap caught after reset release
  logic strap_done_ff, nxt_strap_done;
  logic [3:0] gin_s1_ff, gin_s2_ff; // General pin input synchroniser
  logic ptog_s1_ff, ptog_s2_ff, ptog_s3_ff; // Pixel window toggle
  logic [7:0] pcnt_ff, nxt_pcnt; // Core cycles since last window
  logic in_range_ff, nxt_in_range; // Pixel clock within selected range
  logic sec_core; // Secondary mode in core domain

  // Link domain state
  logic lrst_s1_ff, lrst_n_ff; // Reset carried into link domain
  logic [13:0] cfg_word, cfg_l; // Settings crossing to link domain
  logic pll_l, sec_l, ovr_l;
  logic [2:0] code_l;
  logic [PKT_W-1:0] dec; // Decrypted packet
  logic take_pkt;
  logic [7:0] div_ff, nxt_div; // Link cycles per bit clock period
  logic [2:0] base_ff, nxt_base; // Select code meaning x1
  logic seen_ff, nxt_seen; // Clock information received
  logic pend_v_ff, nxt_pend_v; // One packet waiting to be shifted
  logic [PKT_W-1:0] pend_ff, nxt_pend;
  logic [PKT_W-1:0] shf_ff, nxt_shf; // Packet being shifted out
  logic [3:0] left_ff, nxt_left; // Slots left in shifter
  logic [7:0] bcnt_ff, nxt_bcnt; // Bit clock half period counter
  logic bclk_ff, nxt_bclk;
  logic wc_ff, nxt_wc, pri_ff, nxt_pri, sec_ff, nxt_sec;
  logic [1:0] mult_l; // log2 of master clock multiple
  logic [7:0] mhalf; // Master clock half period
  logic [7:0] mcnt_ff, nxt_mcnt;
  logic mclk_ff, nxt_mclk;
  logic [3:0] win_ff, nxt_win; // Pixel clock window counter
  logic ptog_ff, nxt_ptog;
  logic [3:0] gout_ff, gdrv_ff;

  // Bus decode: index is byte address over four
  logic bus_req;
  logic [7:0] bus_idx;
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign bus_idx = {2'h0, wb_adr_i[7:2]};
  assign sec_core = strap_ff || ctl_ff[CTL_SECONDARY];

  // Register file, bus answer and strap capture
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_mcs = mcs_ff;
    nxt_gpc = gpc_ff;
    nxt_rdat = rdat_ff;
    nxt_ack = bus_req; // One wait state, ack lasts one cycle
    nxt_strap = strap_ff;
    nxt_strap_done = 1'b1;
    if (!strap_done_ff) begin
      nxt_strap = strap_s2_ff; // Caught once, after reset release
    end
    if (bus_req) begin
      nxt_rdat = 32'h0;
      // Unmapped indices answer with zero and ignore writes
      unique case (bus_idx)
        IDX_AUDIO_CONTROL: begin
          nxt_rdat = {24'h0, ctl_ff};
          if (wb_we_i && wb_sel_i[0]) nxt_ctl = wb_dat_i[7:0];
        end
        IDX_MASTER_CLOCK_SELECT: begin
          nxt_rdat = {24'h0, mcs_ff};
          if (wb_we_i && wb_sel_i[0]) nxt_mcs = wb_dat_i[7:0];
        end
        IDX_GPIO_CONTROL: begin
          nxt_rdat = {24'h0, gpc_ff};
          if (wb_we_i && wb_sel_i[0]) nxt_gpc = wb_dat_i[7:0];
        end
        IDX_AUDIO_STATUS: begin
          nxt_rdat = {24'h0, 1'b0, sec_core, strap_ff, in_range_ff, gin_s2_ff};
        end
        default: begin
          nxt_rdat = 32'h0;
        end
      endcase
    end
  end

  // Pixel clock range check: window length in core cycles
  always_comb begin
    nxt_pcnt = (pcnt_ff == 8'hff) ? pcnt_ff : pcnt_ff + 8'h01;
    nxt_in_range = in_range_ff;
    if (ptog_s2_ff != ptog_s3_ff) begin
      nxt_pcnt = 8'h00;
      if (ctl_ff[CTL_LOW_FREQ]) begin
        nxt_in_range = (pcnt_ff >= CNT_LO_MIN) && (pcnt_ff <= CNT_LO_MAX);
      end else begin
        nxt_in_range = (pcnt_ff >= CNT_HI_MIN) && (pcnt_ff <= CNT_HI_MAX);
      end
    end else if (pcnt_ff == 8'hff) begin
      nxt_in_range = 1'b0; // Clock stopped
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_ff <= CTL_RESET;
      mcs_ff <= MCS_RESET;
      gpc_ff <= GPIO_RESET;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
      strap_ff <= 1'b0;
      strap_done_ff <= 1'b0;
      pcnt_ff <= 8'h00;
      in_range_ff <= 1'b0;
    end else begin
      ctl_ff <= nxt_ctl;
      mcs_ff <= nxt_mcs;
      gpc_ff <= nxt_gpc;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      strap_ff <= nxt_strap;
      strap_done_ff <= nxt_strap_done;
      pcnt_ff <= nxt_pcnt;
      in_range_ff <= nxt_in_range;
    end
  end

  // Synchronisers carry no reset; their first stage feeds only the second
  always_ff @(posedge core_clk) begin
    strap_s1_ff <= strap_secondary;
    strap_s2_ff <= strap_s1_ff;
    gin_s1_ff <= gpio_i;
    gin_s2_ff <= gin_s1_ff;
    ptog_s1_ff <= ptog_ff;
    ptog_s2_ff <= ptog_s1_ff;
    ptog_s3_ff <= ptog_s2_ff;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign low_frequency_mode = ctl_ff[CTL_LOW_FREQ];
  assign secondary_mode = sec_core;

  // Settings cross as one word so the code field never arrives torn
  assign cfg_word = {ctl_ff[CTL_PLL_ENABLE], sec_core, mcs_ff[MCS_OVERRIDE],
                     mcs_ff[MCS_CODE_LSB +: 3], gpc_ff};
  dao_word_sync #(.W(14)) u_cfg_sync (
    .src_clk(core_clk),
    .src_rst_n(rst_n),
    .src_word(cfg_word),
    .dst_clk(link_clk),
    .dst_rst_n(lrst_n_ff),
    .dst_word(cfg_l)
  );
  assign pll_l = cfg_l[13];
  assign sec_l = cfg_l[12];
  assign ovr_l = cfg_l[11];
  assign code_l = cfg_l[10:8];
  assign gdrv_ff = cfg_l[7:4];
  assign gout_ff = cfg_l[3:0];

  // Reset reaches the link domain through two flops
  always_ff @(posedge link_clk) begin
    lrst_s1_ff <= rst_n;
    lrst_n_ff <= lrst_s1_ff;
  end

  // Packet intake, decryption, bit clock and serialiser
  assign dec = pkt_word ^ keystream;
  assign take_pkt = pkt_valid && video_blank && (pkt_kind == PKT_CLOCK || !pend_v_ff);

  always_comb begin
    nxt_div = div_ff;
    nxt_base = base_ff;
    nxt_seen = seen_ff;
    nxt_pend = pend_ff;
    nxt_pend_v = pend_v_ff;
    nxt_shf = shf_ff;
    nxt_left = left_ff;
    nxt_bcnt = bcnt_ff + 8'h01;
    nxt_bclk = bclk_ff;
    nxt_wc = wc_ff;
    nxt_pri = pri_ff;
    nxt_sec = sec_ff;
    if (take_pkt && pkt_kind == PKT_CLOCK) begin
      // Dividers below four would outrun a quarter of the pixel clock
      nxt_div = (dec[DIV_LSB +: 8] < DIV_MIN) ? DIV_MIN : dec[DIV_LSB +: 8];
      nxt_base = dec[BASE_LSB +: 3];
      nxt_seen = 1'b1;
    end else if (take_pkt) begin
      nxt_pend = dec;
      nxt_pend_v = 1'b1;
    end
    if (!seen_ff) begin
      nxt_bcnt = 8'h00;
    end else if (bcnt_ff >= (div_ff >> 1) - 8'h01) begin
      nxt_bcnt = 8'h00;
      nxt_bclk = ~bclk_ff;
      if (bclk_ff) begin
        // Falling edge: present the next slot, receiver samples on rise
        if (left_ff == 4'h0 && pend_v_ff) begin
          nxt_shf = pend_ff >> 1;
          nxt_left = 4'(SLOTS - 1);
          nxt_pend_v = take_pkt && pkt_kind == PKT_DATA;
          nxt_wc = pend_ff[WC_LSB];
          nxt_pri = pend_ff[PRI_LSB];
          nxt_sec = pend_ff[SEC_LSB] && sec_l;
        end else if (left_ff != 4'h0) begin
          nxt_shf = shf_ff >> 1;
          nxt_left = left_ff - 4'h1;
          nxt_wc = shf_ff[WC_LSB];
          nxt_pri = shf_ff[PRI_LSB];
          nxt_sec = shf_ff[SEC_LSB] && sec_l;
        end
      end
    end
  end

  // Master clock multiple: code above the base doubles per step
  always_comb begin
    mult_l = MULT_LOG2_DEFAULT;
    if (ovr_l) begin
      if (code_l <= base_ff) mult_l = 2'h0;
      else if (code_l - base_ff >= 3'(MULT_LOG2_MAX)) mult_l = MULT_LOG2_MAX;
      else mult_l = 2'(code_l - base_ff);
    end
    mhalf = div_ff >> (mult_l + 2'h1);
    if (mhalf == 8'h00) mhalf = 8'h01;
    nxt_mcnt = mcnt_ff + 8'h01;
    nxt_mclk = mclk_ff;
    if (!pll_l || !seen_ff) begin
      nxt_mcnt = 8'h00;
      nxt_mclk = 1'b0;
    end else if (mcnt_ff >= mhalf - 8'h01) begin
      nxt_mcnt = 8'h00;
      nxt_mclk = ~mclk_ff;
    end
    nxt_win = win_ff + 4'h1;
    nxt_ptog = (win_ff == 4'hf) ? ~ptog_ff : ptog_ff;
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n_ff) begin
      div_ff <= DIV_MIN;
      base_ff <= 3'h0;
      seen_ff <= 1'b0;
      pend_ff <= '0;
      pend_v_ff <= 1'b0;
      shf_ff <= '0;
      left_ff <= 4'h0;
      bcnt_ff <= 8'h00;
      bclk_ff <= 1'b0;
      wc_ff <= 1'b0;
      pri_ff <= 1'b0;
      sec_ff <= 1'b0;
      mcnt_ff <= 8'h00;
      mclk_ff <= 1'b0;
      win_ff <= 4'h0;
      ptog_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      base_ff <= nxt_base;
      seen_ff <= nxt_seen;
      pend_ff <= nxt_pend;
      pend_v_ff <= nxt_pend_v;
      shf_ff <= nxt_shf;
      left_ff <= nxt_left;
      bcnt_ff <= nxt_bcnt;
      bclk_ff <= nxt_bclk;
      wc_ff <= nxt_wc;
      pri_ff <= nxt_pri;
      sec_ff <= nxt_sec;
      mcnt_ff <= nxt_mcnt;
      mclk_ff <= nxt_mclk;
      win_ff <= nxt_win;
      ptog_ff <= nxt_ptog;
    end
  end

  // Serial audio pins come straight from flops
  assign audio_bit_clock = bclk_ff;
  assign audio_word_clock = wc_ff;
  assign audio_primary_data = pri_ff;
  assign audio_secondary_data = sec_ff;
  assign audio_master_clock = mclk_ff;
  // General pins drive only in secondary mode; direction is software's job
  assign gpio_o = gout_ff;
  assign gpio_oe = sec_l ? gdrv_ff : 4'h0;

  chk_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
  chk_mcs_reset_x2: assert property (@(posedge core_clk)
    $rose(rst_n) |-> (mcs_ff == MCS_RESET) && !mcs_ff[MCS_OVERRIDE])
    else $error("master clock select not x2 after reset");
  chk_sec_mode_or: assert property (@(posedge core_clk) disable iff (!rst_n)
    (strap_ff && strap_done_ff) |-> secondary_mode) else $error("strap ignored");
  chk_range_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ptog_s2_ff != ptog_s3_ff) && ctl_ff[CTL_LOW_FREQ] && pcnt_ff < CNT_LO_MIN |=> !in_range_ff)
    else $error("fast clock accepted in low mode");
  chk_mclk_off: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    !pll_l |=> !audio_master_clock) else $error("master clock runs without pll");
  chk_blank_only: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    $changed(div_ff) |-> $past(video_blank) && $past(pkt_valid)) else $error("packet taken outside blank");
  chk_decrypt_pend: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    take_pkt && pkt_kind == PKT_DATA |=> pend_ff == $past(pkt_word ^ keystream))
    else $error("pending word not decrypted");
  chk_data_on_fall: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    $changed(audio_primary_data) |-> $fell(audio_bit_clock)) else $error("data moved off falling edge");
  chk_sec_quiet: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    !sec_l && $fell(audio_bit_clock) |-> !audio_secondary_data) else $error("secondary data in 24-bit mode");
  chk_gpio_24bit: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    !sec_l |-> gpio_oe == 4'h0) else $error("general pins driven in 24-bit mode");
  chk_mult_step: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    ovr_l && code_l == base_ff + 3'h2 && base_ff < 3'h6 |-> mult_l == 2'h2) else $error("x4 code misread");
endmodule
`default_nettype wire

// *** hw/dao_pkg.sv ***
/*
  Shared constants of the deserializer audio output block: register indices,
  field positions, reset values, packet layout and clock-rate figures.
  Assumes a core clock of 40 MHz and a Wishbone bus with 32-bit data.
*/
package dao_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_AUDIO_CONTROL = 8'h2b;
  localparam logic [7:0] IDX_MASTER_CLOCK_SELECT = 8'h3a;
  localparam logic [7:0] IDX_GPIO_CONTROL = 8'h20;
  localparam logic [7:0] IDX_AUDIO_STATUS = 8'h21;
  // Audio control fields
  localparam int CTL_PLL_ENABLE = 0;
  localparam int CTL_SECONDARY = 1;
  localparam int CTL_LOW_FREQ = 2;
  localparam logic [7:0] CTL_RESET = 8'h01;
  // Master clock select fields
  localparam int MCS_OVERRIDE = 7;
  localparam int MCS_CODE_LSB = 4;
  localparam logic [7:0] MCS_RESET = 8'h10;
  // Default multiple when not overridden: x2 is 2**1
  localparam logic [1:0] MULT_LOG2_DEFAULT = 2'h1;
  localparam logic [1:0] MULT_LOG2_MAX = 2'h2;
  localparam logic [7:0] GPIO_RESET = 8'h00;
  // Packet kinds and layout
  localparam logic PKT_DATA = 1'b0;
  localparam logic PKT_CLOCK = 1'b1;
  localparam int SLOTS = 8;
  localparam int WC_LSB = 0;
  localparam int PRI_LSB = 8;
  localparam int SEC_LSB = 16;
  localparam int DIV_LSB = 0;
  localparam int BASE_LSB = 8;
  // Bit clock must not exceed a quarter of the pixel clock
  localparam logic [7:0] DIV_MIN = 8'h04;
  // Pixel clock range check
  localparam int CORE_MHZ = 40;
  localparam int PCLK_WIN = 16;
  localparam int PCLK_MAX_MHZ = 85;
  localparam int PCLK_MID_MHZ = 15;
  localparam int PCLK_MIN_MHZ = 5;
  localparam logic [7:0] CNT_HI_MIN = 8'((PCLK_WIN * CORE_MHZ) / PCLK_MAX_MHZ);
  localparam logic [7:0] CNT_HI_MAX = 8'((PCLK_WIN * CORE_MHZ) / PCLK_MID_MHZ);
  localparam logic [7:0] CNT_LO_MIN = 8'((PCLK_WIN * CORE_MHZ) / PCLK_MID_MHZ + 1);
  localparam logic [7:0] CNT_LO_MAX = 8'((PCLK_WIN * CORE_MHZ) / PCLK_MIN_MHZ);
endpackage

// *** hw/dao_word_sync.sv ***
/*
  Handshake crossing for a slowly changing word, from a source clock to a
  destination clock. Assumes both resets are synchronous, active low.
*/
`timescale 1ns/10ps
`default_nettype none
module dao_word_sync #(
  parameter int W = 8
) (
  // Source side
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic [W-1:0] src_word,
  // Destination side
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic [W-1:0] dst_word
);
  initial begin
    if (W < 1) $error("dao_word_sync: width must be positive");
  end

  logic [W-1:0] held_ff, nxt_held; // Word in flight, stable while busy
  logic req_ff, nxt_req; // Toggles once per word sent
  logic ack_s1_ff, ack_s2_ff; // Ack toggle back in source domain
  logic req_s1_ff, req_s2_ff, req_s3_ff; // Req toggle in destination domain
  logic [W-1:0] dst_ff, nxt_dst; // Word as seen by destination

  // Source: send a new word only once the last one was acknowledged
  always_comb begin
    nxt_held = held_ff;
    nxt_req = req_ff;
    if ((req_ff == ack_s2_ff) && (src_word != held_ff)) begin
      nxt_held = src_word;
      nxt_req = ~req_ff;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      held_ff <= '0;
      req_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      held_ff <= nxt_held;
      req_ff <= nxt_req;
      ack_s1_ff <= req_s3_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // Destination: held word is stable when the toggle edge is seen
  always_comb begin
    nxt_dst = dst_ff;
    if (req_s2_ff != req_s3_ff) begin
      nxt_dst = held_ff;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
      dst_ff <= '0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      dst_ff <= nxt_dst;
    end
  end

  assign dst_word = dst_ff;
endmodule
`default_nettype wire

// *** verif/dao_codec_model.sv ***
/*
  Behavioural downstream codec for the serial audio outputs.
  Assumes data lines change on the falling bit clock and samples them on the
  rising edge; keeps the last eight slots of each line, oldest in bit 0.
*/
`timescale 1ns/10ps
`default_nettype none
module dao_codec_model (
  // Serial audio from the block
  input wire logic audio_bit_clock,
  input wire logic audio_word_clock,
  input wire logic audio_primary_data,
  input wire logic audio_secondary_data,
  // Last eight slots seen on each line
  output logic [7:0] wc_byte,
  output logic [7:0] pri_byte,
  output logic [7:0] sec_byte
);
  // Start from zero so a frame that never arrives cannot match by chance
  initial begin
    wc_byte = 8'h00;
    pri_byte = 8'h00;
    sec_byte = 8'h00;
  end
  // Sample mid-bit on the rising edge, new slot enters at the top
  always @(posedge audio_bit_clock) begin
    wc_byte <= {audio_word_clock, wc_byte[7:1]};
    pri_byte <= {audio_primary_data, pri_byte[7:1]};
    sec_byte <= {audio_secondary_data, sec_byte[7:1]};
  end
endmodule
`default_nettype wire

// *** verif/dao_audio_out_tb.sv ***
/*
  Self-checking bench for the audio output block: Wishbone register tasks,
  link packet driver and period measurement on the link clock.
  Assumes the codec model at the serial pins and free-running clocks.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dao_audio_out_tb
  import dao_pkg::*;
;
  // Clocks, reset and counters
  logic core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  // Bus and link stimulus
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic strap_secondary = 1'b0, video_blank = 1'b0, pkt_valid = 1'b0, pkt_kind = 1'b0;
  logic [23:0] pkt_word = 24'h0, keystream = 24'h0;
  // Outputs and pins
  logic bclk, wclk, pdat, sdat, mclk, lfm, smode;
  logic [3:0] gpio_o, gpio_oe;
  logic [7:0] cap_wc, cap_pri, cap_sec;
  int per, c;
  // Pins resolve from the block's enables, the far side pulls to 4'h9
  wire [3:0] gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & 4'h9);

  always #12.5 core_clk = ~core_clk;
  always #16 link_clk = ~link_clk;

  dao_audio_out dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .strap_secondary(strap_secondary), .link_clk(link_clk), .video_blank(video_blank),
    .pkt_valid(pkt_valid), .pkt_kind(pkt_kind), .pkt_word(pkt_word), .keystream(keystream),
    .audio_bit_clock(bclk), .audio_word_clock(wclk), .audio_primary_data(pdat),
    .audio_secondary_data(sdat), .audio_master_clock(mclk), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .low_frequency_mode(lfm), .secondary_mode(smode));
  dao_codec_model codec (.audio_bit_clock(bclk), .audio_word_clock(wclk), .audio_primary_data(pdat),
    .audio_secondary_data(sdat), .wc_byte(cap_wc), .pri_byte(cap_pri), .sec_byte(cap_sec));

  // Verdict and the only way out of the run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb_xfer(input logic [7:0] idx, input logic we, input logic [7:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx[5:0], 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) n_mismatch++;
  endtask

  task automatic wait_link(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // One packet for one link cycle; the payload inverts once released
  task automatic send_pkt(input logic kind, input logic [23:0] plain, input logic [23:0] ks, input logic blank);
    @(posedge link_clk);
    video_blank <= blank;
    pkt_valid <= 1'b1;
    pkt_kind <= kind;
    pkt_word <= plain ^ ks;
    keystream <= ks;
    @(posedge link_clk);
    video_blank <= 1'b0;
    pkt_valid <= 1'b0;
    pkt_word <= ~(plain ^ ks);
  endtask

  // Period in link cycles between two rising edges, 0 if none seen
  task automatic measure(input logic use_m, output int p);
    logic prev, s;
    int t0;
    prev = 1'b1;
    t0 = -1;
    p = 0;
    for (int k = 0; k < 200 && p == 0; k++) begin
      @(posedge link_clk);
      #1;
      s = use_m ? mclk : bclk;
      if (s === 1'b1 && prev === 1'b0) begin
        if (t0 < 0) t0 = k;
        else p = k - t0;
      end
      prev = s;
    end
  endtask

  // Wait for a frame at the codec, then compare all three lines together
  task automatic expect_frame(input logic [7:0] w, input logic [7:0] p, input logic [7:0] s);
    int n;
    n = 0;
    while (cap_wc !== w && n < 400) begin
      @(posedge link_clk);
      n++;
    end
    `CHK({cap_wc, cap_pri, cap_sec}, {w, p, s})
  endtask

  initial begin
    repeat (4) @(posedge link_clk);
    @(posedge core_clk);
    rst_n <= 1'b1;
    wb_xfer(IDX_AUDIO_CONTROL, 1'b0, 8'h00, rd);
    `CHK(rd, {24'h0, CTL_RESET})
    wb_xfer(IDX_MASTER_CLOCK_SELECT, 1'b0, 8'h00, rd);
    `CHK(rd, 32'h00000010)
    wb_xfer(8'h30, 1'b1, 8'hff, rd);
    wb_xfer(8'h30, 1'b0, 8'h00, rd);
    `CHK(rd, 32'h0)
    $display("test registers done");
    // Clock info: divider 8 keeps the bit rate under a quarter, base code 1
    send_pkt(PKT_CLOCK, 24'h000108, 24'h3cc35a, 1'b1);
    wait_link(20);
    measure(1'b0, per);
    `CHK(per, 8)
    measure(1'b1, per);
    `CHK(per, 4)
    $display("test clocks done");
    // Secondary line stays low outside secondary mode
    send_pkt(PKT_DATA, 24'h3ca5f0, 24'h5a5a5a, 1'b1);
    expect_frame(8'hf0, 8'ha5, 8'h00);
    wb_xfer(IDX_AUDIO_CONTROL, 1'b1, 8'h03, rd);
    wait_link(40);
    `CHK(smode, 1'b1)
    send_pkt(PKT_DATA, 24'hc35a0f, 24'h96e712, 1'b1);
    expect_frame(8'h0f, 8'h5a, 8'hc3);
    $display("test frames done");
    // Override first, then step the code: each step doubles the rate
    wb_xfer(IDX_MASTER_CLOCK_SELECT, 1'b1, 8'h80, rd);
    for (c = 1; c <= 3; c++) begin
      wb_xfer(IDX_MASTER_CLOCK_SELECT, 1'b1, {1'b1, 3'(c), 4'h0}, rd);
      wait_link(40);
      measure(1'b1, per);
      `CHK(per, 8 >> (c - 1))
    end
    wb_xfer(IDX_AUDIO_CONTROL, 1'b1, 8'h02, rd);
    wait_link(40);
    measure(1'b1, per);
    `CHK({per, mclk}, {32'd0, 1'b0})
    $display("test master clock done");
    // General pins in secondary mode, then the status word
    wb_xfer(IDX_GPIO_CONTROL, 1'b1, 8'ha5, rd);
    wait_link(100);
    `CHK({gpio_oe, gpio_o}, 8'ha5)
    wb_xfer(IDX_AUDIO_STATUS, 1'b0, 8'h00, rd);
    `CHK(rd[6:0], 7'h51)
    wb_xfer(IDX_AUDIO_CONTROL, 1'b1, 8'h07, rd);
    wait_link(100);
    wb_xfer(IDX_AUDIO_STATUS, 1'b0, 8'h00, rd);
    `CHK({lfm, rd[4]}, 2'b10)
    $display("test pins and status done");
    // A packet outside blanking must leave the lines idle
    send_pkt(PKT_DATA, 24'h3ca5f0, 24'h000000, 1'b0);
    wait_link(200);
    `CHK(cap_wc, 8'h00)
    // Second reset with the strap high selects secondary mode by itself
    @(posedge core_clk);
    strap_secondary <= 1'b1;
    rst_n <= 1'b0;
    repeat (4) @(posedge link_clk);
    @(posedge core_clk);
    rst_n <= 1'b1;
    wb_xfer(IDX_AUDIO_CONTROL, 1'b0, 8'h00, rd);
    `CHK({rd, smode}, {24'h0, CTL_RESET, 1'b1})
    $display("test strap done");
    end_sim();
  end
endmodule
`default_nettype wire
